// ---- logic/rfrs_pkg.sv ----
package rfrs_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_IND_EN = 8'hB0;
  localparam logic [7:0] ADDR_RESP_A = 8'hB2;
  localparam logic [7:0] ADDR_RESP_B = 8'hB3;
  localparam logic [7:0] ADDR_STAT_A = 8'hD2;
  localparam logic [7:0] ADDR_STAT_B = 8'hD3;
  // Field positions
  localparam int IND_EN_BIT = 7;
  localparam int HB_UV_LSB = 6;
  localparam int DRV_OV_LSB = 0;
  localparam int DRV_UV_LSB = 2;
  localparam int CORE_OV_LSB = 4;
  localparam int CORE_UV_LSB = 6;
  localparam int HB_UV_STAT = 7;
  localparam int DRV_OV_STAT = 2;
  localparam int DRV_UV_STAT = 3;
  localparam int CORE_OV_STAT = 0;
  localparam int CORE_UV_STAT = 1;
  // Reset values
  localparam logic IND_EN_RST = 1'b0;
  localparam logic [1:0] RESP_A_RST = 2'h0;
  localparam logic [7:0] RESP_B_RST = 8'h00;
  localparam logic STAT_A_RST = 1'b0;
  localparam logic [3:0] STAT_B_RST = 4'h0;
  // ==========================================================
  // Monitor channels and synchroniser lanes
  localparam int NCH = 5;
  localparam int CH_HB_UV = 0;
  localparam int CH_DRV_OV = 1;
  localparam int CH_DRV_UV = 2;
  localparam int CH_CORE_OV = 3;
  localparam int CH_CORE_UV = 4;
  localparam int SYNC_W = 10;
  localparam int SY_FAULT_LSB = 0;
  localparam int SY_MODE_LSB = 5;
  localparam int SY_SW = 7;
  localparam int SY_CHIP = 8;
  localparam int SY_WP = 9;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int HICCUP_MS = 500;
  localparam int HICCUP_CYC_DFLT = HICCUP_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 26;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    RESP_FLAG = 2'b00,
    RESP_HICCUP = 2'b01,
    RESP_LATCH = 2'b10,
    RESP_FLAG_ALT = 2'b11
  } rfrs_resp_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_WAIT = 2'b10,
    ST_LATCH = 2'b11
  } rfrs_state_t;
  // Register field wins only with the global enable set
  function automatic rfrs_resp_t rfrs_pick(input logic ind_en,
                                           input logic [1:0] field,
                                           input logic [1:0] mode);
    rfrs_pick = rfrs_resp_t'(ind_en ? field : mode);
  endfunction
endpackage

// ---- logic/rfrs_ch_if.sv ----
interface rfrs_ch_if;
  import rfrs_pkg::*;
  logic fault;
  logic toggle;
  rfrs_resp_t resp;
  logic stop;
  modport ctl (output fault, output toggle, output resp, input stop);
  modport ch (input fault, input toggle, input resp, output stop);
endinterface

// ---- logic/rfrs_sync.sv ----
module rfrs_sync
  import rfrs_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // ==========================================================
  // Filter: a lane moves only once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule // rfrs_sync

// ---- logic/rfrs_channel.sv ----
module rfrs_channel
  import rfrs_pkg::*;
#(
  parameter int HICCUP_CYC = HICCUP_CYC_DFLT
) (
  input wire logic clock,
  input wire logic rst,
  rfrs_ch_if.ch cif
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(HICCUP_CYC - 1);
  rfrs_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  // ==========================================================
  // Response sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_RUN: begin
        // Codes 00 and 11 fall through: flag only, switching runs on
        if (cif.fault && cif.resp == RESP_HICCUP) begin
          state_d = ST_HALT;
        end else if (cif.fault && cif.resp == RESP_LATCH) begin
          state_d = ST_LATCH;
        end
      end
      ST_HALT: begin
        if (!cif.fault) begin
          state_d = ST_WAIT;
          cnt_d = '0;
        end
      end
      ST_WAIT: begin
        if (cif.fault) begin
          state_d = ST_HALT;
          cnt_d = '0;
        end else if (cnt_q == LAST) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = CNT_W'(cnt_q + 1'b1);
        end
      end
      ST_LATCH: begin
        // Only an enable edge frees it; status clear does not
        if (cif.toggle) begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign cif.stop = (state_q != ST_RUN);

  // ==========================================================
  // Checks
  property p_halt;
    @(posedge clock) disable iff (rst)
    (state_q == ST_RUN && cif.fault && cif.resp inside {RESP_HICCUP, RESP_LATCH})
      |=> cif.stop;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt on fault");

  property p_flag_only;
    @(posedge clock) disable iff (rst)
    (state_q == ST_RUN && cif.resp inside {RESP_FLAG, RESP_FLAG_ALT}) |=> !cif.stop;
  endproperty
  a_flag_only: assert property (p_flag_only) else $error("flag mode halted");

  property p_restart;
    @(posedge clock) disable iff (rst)
    (state_q == ST_WAIT && !cif.fault && cnt_q == LAST) |=> (state_q == ST_RUN);
  endproperty
  a_restart: assert property (p_restart) else $error("hiccup did not restart");

  property p_wait_reset;
    @(posedge clock) disable iff (rst)
    (state_q == ST_WAIT && cif.fault) |=> (state_q == ST_HALT) ##1 (cnt_q == '0 || !cif.fault);
  endproperty
  a_wait_reset: assert property (p_wait_reset) else $error("delay not restarted");

  property p_latch_hold;
    @(posedge clock) disable iff (rst)
    (state_q == ST_LATCH && !cif.toggle) |=> (state_q == ST_LATCH);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released");
endmodule // rfrs_channel

// ---- logic/rfrs_top.sv ----
module rfrs_top
  import rfrs_pkg::*;
#(
  parameter int HICCUP_CYC = HICCUP_CYC_DFLT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [NCH-1:0] rail_fault,
  input wire logic [1:0] mode_resp,
  input wire logic sw_enable,
  input wire logic chip_enable,
  input wire logic write_protect,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe,
  output logic switching_halt
);
  // ==========================================================
  // Pin synchronisation
  logic [SYNC_W-1:0] sync_in, sync_out;
  logic [NCH-1:0] fault_s;
  logic [1:0] mode_s;
  logic sw_s, chip_s, wp_s;

  assign sync_in = {write_protect, chip_enable, sw_enable, mode_resp, rail_fault};

  rfrs_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .din(sync_in),
    .dout(sync_out)
  );

  assign fault_s = sync_out[SY_FAULT_LSB +: NCH];
  assign mode_s = sync_out[SY_MODE_LSB +: 2];
  assign sw_s = sync_out[SY_SW];
  assign chip_s = sync_out[SY_CHIP];
  assign wp_s = sync_out[SY_WP];

  // ==========================================================
  // Control registers
  logic ind_en_q, ind_en_d;
  logic [1:0] resp_a_q, resp_a_d;
  logic [7:0] resp_b_q, resp_b_d;
  logic ctl_wr;

  // Protection blocks control writes only; status clears still pass
  assign ctl_wr = reg_wr && !wp_s;

  always_comb begin
    ind_en_d = ind_en_q;
    resp_a_d = resp_a_q;
    resp_b_d = resp_b_q;
    if (ctl_wr && reg_addr == ADDR_IND_EN) begin
      ind_en_d = reg_wdata[IND_EN_BIT];
    end
    if (ctl_wr && reg_addr == ADDR_RESP_A) begin
      resp_a_d = reg_wdata[HB_UV_LSB +: 2];
    end
    if (ctl_wr && reg_addr == ADDR_RESP_B) begin
      resp_b_d = reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ind_en_q <= IND_EN_RST;
      resp_a_q <= RESP_A_RST;
      resp_b_q <= RESP_B_RST;
    end else begin
      ind_en_q <= ind_en_d;
      resp_a_q <= resp_a_d;
      resp_b_q <= resp_b_d;
    end
  end

  // ==========================================================
  // Sticky status, write one to clear
  logic stat_a_q, stat_a_d;
  logic [3:0] stat_b_q, stat_b_d;
  logic [3:0] set_b;

  always_comb begin
    set_b = 4'h0;
    set_b[DRV_OV_STAT] = fault_s[CH_DRV_OV];
    set_b[DRV_UV_STAT] = fault_s[CH_DRV_UV];
    set_b[CORE_OV_STAT] = fault_s[CH_CORE_OV];
    set_b[CORE_UV_STAT] = fault_s[CH_CORE_UV];
  end

  // Set is applied after clear, so a fault in the clear cycle survives
  always_comb begin
    stat_a_d = stat_a_q;
    stat_b_d = stat_b_q;
    if (reg_wr && reg_addr == ADDR_STAT_A) begin
      stat_a_d = stat_a_q & ~reg_wdata[HB_UV_STAT];
    end
    if (reg_wr && reg_addr == ADDR_STAT_B) begin
      stat_b_d = stat_b_q & ~reg_wdata[3:0];
    end
    stat_a_d = stat_a_d | fault_s[CH_HB_UV];
    stat_b_d = stat_b_d | set_b;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_a_q <= STAT_A_RST;
      stat_b_q <= STAT_B_RST;
    end else begin
      stat_a_q <= stat_a_d;
      stat_b_q <= stat_b_d;
    end
  end

  // ==========================================================
  // Read path, one cycle behind the address
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      ADDR_IND_EN: rdata_d[IND_EN_BIT] = ind_en_q;
      ADDR_RESP_A: rdata_d[HB_UV_LSB +: 2] = resp_a_q;
      ADDR_RESP_B: rdata_d = resp_b_q;
      ADDR_STAT_A: rdata_d[HB_UV_STAT] = stat_a_q;
      ADDR_STAT_B: rdata_d[3:0] = stat_b_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // Response selection and per-rail sequencers
  logic [1:0] field [NCH];
  rfrs_resp_t resp_v [NCH];
  logic [NCH-1:0] stop_v;
  logic [1:0] en_prev_q, en_prev_d;
  logic toggle;

  always_comb begin
    field[CH_HB_UV] = resp_a_q;
    field[CH_DRV_OV] = resp_b_q[DRV_OV_LSB +: 2];
    field[CH_DRV_UV] = resp_b_q[DRV_UV_LSB +: 2];
    field[CH_CORE_OV] = resp_b_q[CORE_OV_LSB +: 2];
    field[CH_CORE_UV] = resp_b_q[CORE_UV_LSB +: 2];
    for (int i = 0; i < NCH; i++) begin
      resp_v[i] = rfrs_pick(ind_en_q, field[i], mode_s);
    end
  end

  // Either enable changing level counts as the release toggle
  assign toggle = (en_prev_q != {chip_s, sw_s});

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    rfrs_ch_if cif ();
    assign cif.fault = fault_s[g];
    assign cif.toggle = toggle;
    assign cif.resp = resp_v[g];
    assign stop_v[g] = cif.stop;
    rfrs_channel #(
      .HICCUP_CYC(HICCUP_CYC)
    ) u_ch (
      .clock(clock),
      .rst(rst),
      .cif(cif.ch)
    );
  end

  // ==========================================================
  // Pin drivers, all registered
  logic flag_n_q, flag_n_d;
  logic flag_oe_q, flag_oe_d;
  logic halt_q, halt_d;

  always_comb begin
    flag_n_d = ~|fault_s;
    flag_oe_d = |fault_s;
    halt_d = |stop_v;
    en_prev_d = {chip_s, sw_s};
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_n_q <= 1'b1;
      flag_oe_q <= 1'b0;
      halt_q <= 1'b0;
      en_prev_q <= 2'h0;
    end else begin
      flag_n_q <= flag_n_d;
      flag_oe_q <= flag_oe_d;
      halt_q <= halt_d;
      en_prev_q <= en_prev_d;
    end
  end

  assign fault_flag_n_out = flag_n_q;
  assign fault_flag_n_oe = flag_oe_q;
  assign switching_halt = halt_q;

  // ==========================================================
  // Checks
  property p_flag_low;
    @(posedge clock) disable iff (rst)
    (|fault_s) |=> (fault_flag_n_oe && !fault_flag_n_out);
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("flag not low");

  property p_mode;
    @(posedge clock) disable iff (rst)
    !ind_en_q |-> (resp_v[CH_DRV_UV] == rfrs_resp_t'(mode_s));
  endproperty
  a_mode: assert property (p_mode) else $error("mode pins ignored");

  property p_stat_hb;
    @(posedge clock) disable iff (rst)
    fault_s[CH_HB_UV] |=> stat_a_q;
  endproperty
  a_stat_hb: assert property (p_stat_hb) else $error("hb status missed");

  property p_stat_drv_ov;
    @(posedge clock) disable iff (rst)
    fault_s[CH_DRV_OV] |=> stat_b_q[DRV_OV_STAT];
  endproperty
  a_stat_drv_ov: assert property (p_stat_drv_ov) else $error("drv ov status");

  property p_stat_drv_uv;
    @(posedge clock) disable iff (rst)
    fault_s[CH_DRV_UV] |=> stat_b_q[DRV_UV_STAT];
  endproperty
  a_stat_drv_uv: assert property (p_stat_drv_uv) else $error("drv uv status");

  property p_stat_core;
    @(posedge clock) disable iff (rst)
    fault_s[CH_CORE_OV] |=> stat_b_q[CORE_OV_STAT];
  endproperty
  a_stat_core: assert property (p_stat_core) else $error("core ov status");

  property p_stat_core_uv;
    @(posedge clock) disable iff (rst)
    fault_s[CH_CORE_UV] |=> stat_b_q[CORE_UV_STAT];
  endproperty
  a_stat_core_uv: assert property (p_stat_core_uv) else $error("core uv status");

  property p_field_map;
    @(posedge clock) disable iff (rst)
    ind_en_q |-> (resp_v[CH_CORE_UV] == rfrs_resp_t'(resp_b_q[7:6]))
      && (resp_v[CH_DRV_OV] == rfrs_resp_t'(resp_b_q[1:0]));
  endproperty
  a_field_map: assert property (p_field_map) else $error("field map wrong");

  property p_b3_write;
    @(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_RESP_B)
      |=> resp_b_q == ($past(wp_s) ? $past(resp_b_q) : $past(reg_wdata));
  endproperty
  a_b3_write: assert property (p_b3_write) else $error("0xB3 write wrong");

  property p_sticky;
    @(posedge clock) disable iff (rst)
    (stat_b_q[DRV_OV_STAT] && !(reg_wr && reg_addr == ADDR_STAT_B))
      |=> stat_b_q[DRV_OV_STAT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status not sticky");

  // Flag must let go once every rail is clean, or it would mask the next fault
  property p_flag_high;
    @(posedge clock) disable iff (rst)
    !(|fault_s) |=> (fault_flag_n_out && !fault_flag_n_oe);
  endproperty
  a_flag_high: assert property (p_flag_high) else $error("flag stuck low");

  property p_halt_out;
    @(posedge clock) disable iff (rst)
    (|stop_v) |=> switching_halt;
  endproperty
  a_halt_out: assert property (p_halt_out) else $error("halt pin not driven");
endmodule // rfrs_top

// ---- bench/rfrs_ctl_model.sv ----
// ==========================================================
// System controller side: owns the two enable pins
module rfrs_ctl_model (
  input wire logic clock,
  input wire logic toggle_req,
  output logic sw_enable,
  output logic chip_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pick_chip;
  initial begin
    sw_enable = 1'b1;
    chip_enable = 1'b1;
    pick_chip = 1'b0;
  end
  // Alternate pins so both toggle paths release a latch
  always @(negedge clock) begin
    if (toggle_req === 1'b1) begin
      if (pick_chip) chip_enable <= ~chip_enable;
      else sw_enable <= ~sw_enable;
      pick_chip <= ~pick_chip;
    end
  end
endmodule // rfrs_ctl_model

// ---- bench/testbench.sv ----
// ==========================================================
// Self-checking bench for the rail fault response block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rfrs_pkg::*;
  typedef struct {
    logic [10:0] v;
    logic [10:0] m;
  } rfrs_exp_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [NCH-1:0] rail_fault = '0;
  logic [1:0] mode_resp = 2'h0;
  logic write_protect = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic toggle_req = 1'b0;
  logic chk = 1'b0;
  logic sw_enable, chip_enable, fault_flag_n_out, fault_flag_n_oe, switching_halt;
  logic [7:0] reg_rdata;
  int n_mismatch = 0;
  int tests_run = 0;
  rfrs_exp_t exp_q[$];
  rfrs_exp_t e;
  // Channel map: field address, field lsb, status address, status bit
  logic [7:0] f_adr [NCH] = '{8'hB2, 8'hB3, 8'hB3, 8'hB3, 8'hB3};
  int f_lsb [NCH] = '{6, 0, 2, 4, 6};
  logic [7:0] s_adr [NCH] = '{8'hD2, 8'hD3, 8'hD3, 8'hD3, 8'hD3};
  int s_bit [NCH] = '{7, 2, 3, 0, 1};

  always #5 clock = ~clock;

  rfrs_top #(.HICCUP_CYC(20)) i_rfrs_top (
    .clock(clock), .rst(rst), .rail_fault(rail_fault), .mode_resp(mode_resp),
    .sw_enable(sw_enable), .chip_enable(chip_enable), .write_protect(write_protect),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe(fault_flag_n_oe),
    .switching_halt(switching_halt)
  );
  rfrs_ctl_model i_rfrs_ctl_model (
    .clock(clock), .toggle_req(toggle_req), .sw_enable(sw_enable),
    .chip_enable(chip_enable)
  );

  // ==========================================================
  // Monitor: oldest note against outputs when a result is flagged
  always @(negedge clock) begin
    if (chk === 1'b1) begin
      e = exp_q.pop_front();
      tests_run++;
      if (({fault_flag_n_out, fault_flag_n_oe, switching_halt, reg_rdata} & e.m) !==
          (e.v & e.m)) begin
        n_mismatch++;
        $display("MISMATCH at %0t: outputs %b %b %b %h, want %h mask %h", $time,
                 fault_flag_n_out, fault_flag_n_oe, switching_halt, reg_rdata, e.v, e.m);
      end
    end
  end

  // ==========================================================
  // Driver tasks, all entered just after a falling edge
  task automatic note(input logic [10:0] v, input logic [10:0] m);
    exp_q.push_back('{v: v, m: m});
    chk <= 1'b1;
    @(negedge clock);
    chk <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr <= a;
    @(negedge clock);
    note({3'b000, d}, 11'h0FF);
  endtask
  task automatic pins(input logic fl_n, input logic oe, input logic halt);
    note({fl_n, oe, halt, 8'h00}, 11'h700);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // One channel, one response code, by register field or by mode pins
  task automatic run_case(input int c, input logic ind, input logic [1:0] r);
    logic halt;
    logic [7:0] sb;
    halt = (r == 2'b01) || (r == 2'b10);
    sb = 8'h01 << s_bit[c];
    wr(8'hB0, {ind, 7'h00});
    mode_resp <= ind ? (r ^ 2'b10) : r;
    wr(f_adr[c], 8'((ind ? r : (r ^ 2'b01))) << f_lsb[c]);
    cyc(6);
    rail_fault[c] <= 1'b1;
    cyc(10);
    pins(1'b0, 1'b1, halt);
    rd(s_adr[c], sb);
    rail_fault[c] <= 1'b0;
    cyc(12);
    pins(1'b1, 1'b0, halt);
    rd(s_adr[c], sb);
    cyc(30);
    pins(1'b1, 1'b0, r == 2'b10);
    if (r == 2'b10) begin
      wr(s_adr[c], sb);
      pins(1'b1, 1'b0, 1'b1);
      toggle_req <= 1'b1;
      @(negedge clock);
      toggle_req <= 1'b0;
      cyc(10);
      pins(1'b1, 1'b0, 1'b0);
    end
    wr(s_adr[c], sb);
    rd(s_adr[c], 8'h00);
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog: tests need about 3400 cycles
  initial begin
    repeat (30000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] v;
    void'($urandom(98));
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst <= 1'b0;
    // Reset values, unmapped address reads zero
    pins(1'b1, 1'b0, 1'b0);
    foreach (s_adr[i]) rd(s_adr[i], 8'h00);
    rd(8'hB0, 8'h00);
    rd(8'hB2, 8'h00);
    rd(8'hB3, 8'h00);
    rd(8'hB1, 8'h00);
    // Full byte read-write, then a write blocked by protection
    v = 8'($urandom);
    wr(8'hB3, v);
    rd(8'hB3, v);
    wr(8'hB2, 8'hFF);
    rd(8'hB2, 8'hC0);
    write_protect <= 1'b1;
    cyc(6);
    wr(8'hB3, ~v);
    rd(8'hB3, v);
    write_protect <= 1'b0;
    cyc(6);
    wr(8'hB2, 8'h00);
    wr(8'hB3, 8'h00);
    // Every channel, every code, field path and pin path
    for (int c = 0; c < NCH; c++) begin
      for (int k = 0; k < 8; k++) begin
        run_case(c, k[2], k[1:0]);
      end
    end
    // Fault returning during the restart delay restarts the count
    wr(8'hB0, 8'h80);
    wr(8'hB3, 8'h01);
    cyc(6);
    rail_fault[1] <= 1'b1;
    cyc(10);
    rail_fault[1] <= 1'b0;
    cyc(12);
    rail_fault[1] <= 1'b1;
    cyc(6);
    rail_fault[1] <= 1'b0;
    cyc(14);
    pins(1'b1, 1'b0, 1'b1);
    cyc(30);
    pins(1'b1, 1'b0, 1'b0);
    wr(8'hD3, 8'h04);
    rd(8'hD3, 8'h00);
    cyc(4);
    tally_and_finish();
  end
endmodule // testbench
